// File: hdl/mmpm_pkg.sv
// Constants, codes and field layouts shared by the slave poll manager.
// Assumes a 40 MHz bus clock and a 32-bit AHB-Lite register bus.
package mmpm_pkg;
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;

    // Register byte offsets
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_MSTAT = 12'h004;
    localparam logic [11:0] A_SLV = 12'h040;
    localparam logic [11:0] A_MSG = 12'h200;
    localparam int SLV_SH = 4;
    localparam int MSG_SH = 3;
    localparam logic [1:0] R_CFG = 2'h0;
    localparam logic [1:0] R_TIM = 2'h1;
    localparam logic [1:0] R_CTL = 2'h2;

    // Field positions
    localparam int CTRL_EN = 0;
    localparam int CFG_NODE = 0;
    localparam int CFG_RTRY = 8;
    localparam int CFG_PMODE = 12;
    localparam int CFG_PADR = 16;
    localparam int TIM_GAP = 0;
    localparam int TIM_PING = 16;
    localparam int MSG_QTY = 16;
    localparam int MSG_USE = 30;
    localparam int MSG_WR = 31;

    // Reset values
    localparam logic [31:0] RST_CFG = 32'h0000_0300;
    localparam logic [31:0] RST_TIM = 32'h03E8_0000;

    // Slave control and status codes
    localparam logic [15:0] CTL_STBY = 16'h0001;
    localparam logic [15:0] CTL_ACT = 16'h0002;
    localparam logic [1:0] STS_OK = 2'h0;
    localparam logic [1:0] STS_UNAV = 2'h1;
    localparam logic [1:0] STS_FAIL = 2'h2;
    localparam logic [1:0] STS_ERR = 2'h3;

    // Function codes
    localparam logic [7:0] FC_RD_COIL = 8'h01;
    localparam logic [7:0] FC_RD_INP = 8'h02;
    localparam logic [7:0] FC_RD_HREG = 8'h03;
    localparam logic [7:0] FC_RD_IREG = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_REG = 8'h06;
    localparam logic [7:0] FC_ECHO = 8'h08;
    localparam logic [7:0] FC_WR_COILS = 8'h15;
    localparam logic [7:0] FC_WR_REGS = 8'h16;
    localparam logic [15:0] SUB_ECHO = 16'h0000;

    // Address ranges and quantities
    localparam logic [15:0] COIL_LO = 16'h0001;
    localparam logic [15:0] COIL_HI = 16'h270F;
    localparam logic [15:0] INP_LO = 16'h2711;
    localparam logic [15:0] INP_HI = 16'h4E1F;
    localparam logic [15:0] IREG_LO = 16'h7531;
    localparam logic [15:0] IREG_HI = 16'h9C3F;
    localparam logic [15:0] HREG_LO = 16'h9C41;
    localparam logic [15:0] HREG_HI = 16'hC34F;
    localparam logic [9:0] Q_1 = 10'h001;
    localparam logic [9:0] Q_2 = 10'h002;
    localparam logic [9:0] Q_BITS = 10'h200;
    localparam logic [9:0] Q_RREGS = 10'h07D;
    localparam logic [9:0] Q_WREGS = 10'h07B;

    typedef enum logic [1:0] {MD_INACT = 2'b00, MD_STBY = 2'b01, MD_ACT = 2'b10} mmpm_mode_t;
    typedef enum logic {ST_PICK = 1'b0, ST_WAIT = 1'b1} mmpm_state_t;
    typedef struct packed {
        logic legal;
        logic [7:0] code;
        logic [15:0] off;
    } mmpm_fc_t;
endpackage

// File: hdl/mmpm_poll_mgr.sv
// Per-slave poll manager of a Modbus master with an AHB-Lite register file.
// Assumes a link engine that frames each request, times out and answers with lnk_done.
//
// Function
// - Try a slave up to the retry count before declaring a failure.
// - Keep at least the configured gap in ms between messages to a slave.
// - Space successive liveness pings by the configured ping interval.
// - Echo ping sends function 08 subfunction 0; the slave echoes it.
// - Register ping reads one register only to prove the link; data dropped.
// - Control 0 idles, 1 pings only, 2 polls the slave for data.
// - Undefined control values behave exactly as inactive.
// - Status 0 when slave answers normally or is set inactive.
// - Status 1 on standby ping failure, master initialising or master inactive.
// - Status 2 while a polled slave does not answer.
// - Status 3 when the slave reports illegal requested values.
// - Messages of a slave go out in list order.
// - Coils 1..9999: read with 0x01, single coil write with 0x05.
// - Writing 2..512 coils uses function 0x15.
// - Discrete inputs 10001..19999: read 1..512 with 0x02.
// - Input registers 30001..39999: read up to 125 with 0x04.
// - Holding registers 40001..49999: read up to 125 with 0x03.
// - Writing one holding register uses 0x06.
// - Writing 2..123 holding registers uses 0x16.
// - A message is sent only while its control value is zero.
// - One message per slave in turn; each list wraps to its first message.
// - Skip disabled messages; a slave with none enabled is pinged as standby.
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mmpm_poll_mgr #(
    parameter int NSLV = 4,
    parameter int NMSG = 4,
    parameter int unsigned MS_CYCLES = mmpm_pkg::MS_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Request to link engine
    output logic lnk_req,
    output logic [7:0] lnk_node,
    output logic [7:0] lnk_func,
    output logic [15:0] lnk_addr,
    output logic [9:0] lnk_qty,
    output logic lnk_write,
    output logic lnk_ping,
    output logic lnk_discard,
    output logic [$clog2(NSLV)-1:0] lnk_slave,
    output logic [$clog2(NMSG)-1:0] lnk_msg,
    // Answer from link engine
    input wire logic lnk_done,
    input wire logic lnk_ok,
    input wire logic lnk_illegal
);
    import mmpm_pkg::*;

    localparam int SW = $clog2(NSLV);
    localparam int MW = $clog2(NMSG);
    localparam int NM = NSLV * NMSG;
    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    typedef struct packed {
        logic [NSLV-1:0][31:0] cfg;
        logic [NSLV-1:0][31:0] tim;
        logic [NSLV-1:0][15:0] ctl;
        logic [NSLV-1:0][1:0] sts;
        logic [NSLV-1:0][16:0] gcnt;
        logic [NSLV-1:0][16:0] pcnt;
        logic [NSLV-1:0][3:0] rtry;
        logic [NSLV-1:0][MW-1:0] ptr;
        logic [NM-1:0][31:0] madr;
        logic [NM-1:0][15:0] mctl;
        logic en;
        mmpm_state_t state;
        logic [SW-1:0] cur;
        logic [MW-1:0] cur_msg;
        logic [31:0] mscnt;
        logic ap_v;
        logic ap_wr;
        logic [11:0] ap_adr;
        logic hrdy;
        logic [31:0] hrdata;
        logic req;
        logic [7:0] node;
        logic [7:0] func;
        logic [15:0] addr;
        logic [9:0] qty;
        logic wr;
        logic ping;
        logic discard;
    } mmpm_st_t;

    mmpm_st_t st_r;
    mmpm_st_t st_nxt;

    function automatic mmpm_mode_t mode_of(input logic [15:0] v);
        case (v)
            CTL_STBY: return MD_STBY;
            CTL_ACT: return MD_ACT;
            default: return MD_INACT;
        endcase
    endfunction

    function automatic logic [16:0] ld_ms(input logic [15:0] v);
        return (v == 16'h0000) ? 17'h00000 : {1'b0, v} + 17'h00001;
    endfunction

    function automatic logic [SW-1:0] nxt_slv(input logic [SW-1:0] v);
        return (int'(v) == NSLV - 1) ? '0 : v + SW'(1);
    endfunction

    function automatic mmpm_fc_t fc_sel(input logic [15:0] a, input logic [9:0] q,
                                        input logic w);
        mmpm_fc_t r;
        r = '0;
        if (a >= COIL_LO && a <= COIL_HI)
        begin
            r.off = a - COIL_LO;
            if (!w && q >= Q_1 && q <= Q_BITS)
                {r.legal, r.code} = {1'b1, FC_RD_COIL};
            else if (w && q == Q_1)
                {r.legal, r.code} = {1'b1, FC_WR_COIL};
            else if (w && q >= Q_2 && q <= Q_BITS)
                {r.legal, r.code} = {1'b1, FC_WR_COILS};
        end
        else if (a >= INP_LO && a <= INP_HI)
        begin
            r.off = a - INP_LO;
            if (!w && q >= Q_1 && q <= Q_BITS)
                {r.legal, r.code} = {1'b1, FC_RD_INP};
        end
        else if (a >= IREG_LO && a <= IREG_HI)
        begin
            r.off = a - IREG_LO;
            if (!w && q >= Q_1 && q <= Q_RREGS)
                {r.legal, r.code} = {1'b1, FC_RD_IREG};
        end
        else if (a >= HREG_LO && a <= HREG_HI)
        begin
            r.off = a - HREG_LO;
            if (!w && q >= Q_1 && q <= Q_RREGS)
                {r.legal, r.code} = {1'b1, FC_RD_HREG};
            else if (w && q == Q_1)
                {r.legal, r.code} = {1'b1, FC_WR_REG};
            else if (w && q >= Q_2 && q <= Q_WREGS)
                {r.legal, r.code} = {1'b1, FC_WR_REGS};
        end
        return r;
    endfunction

    logic tick;
    logic found;
    logic [MW-1:0] fidx;
    logic [MW-1:0] idx;
    logic [SW-1:0] c;
    mmpm_mode_t md;
    mmpm_fc_t fc;
    logic [31:0] mw;
    logic [31:0] rdw;
    logic [4:0] lim;
    int si;
    int mi;

    always_comb
    begin
        st_nxt = st_r;
        c = st_r.cur;
        md = mode_of(st_r.ctl[st_r.cur]);
        found = 1'b0;
        fidx = st_r.ptr[st_r.cur];
        idx = '0;
        fc = '0;
        mw = '0;
        rdw = '0;
        si = 0;
        mi = 0;
        lim = (st_r.cfg[st_r.cur][CFG_RTRY +: 4] == 4'h0) ? 5'h01 :
              {1'b0, st_r.cfg[st_r.cur][CFG_RTRY +: 4]};

        // Millisecond timebase for gap and ping timers
        tick = (st_r.mscnt == MS_LAST);
        st_nxt.mscnt = tick ? 32'h0000_0000 : st_r.mscnt + 32'h0000_0001;
        for (int i = 0; i < NSLV; i++)
        begin
            if (tick && st_r.gcnt[i] != 17'h00000)
                st_nxt.gcnt[i] = st_r.gcnt[i] - 17'h00001;
            if (tick && st_r.pcnt[i] != 17'h00000)
                st_nxt.pcnt[i] = st_r.pcnt[i] - 17'h00001;
        end

        // Bus slave: one wait state, then read data from a flip-flop
        st_nxt.hrdy = 1'b1;
        if (st_r.ap_v)
        begin
            st_nxt.ap_v = 1'b0;
            if (st_r.ap_adr == A_CTRL)
                rdw[CTRL_EN] = st_r.en;
            else if (st_r.ap_adr == A_MSTAT)
                rdw = {16'h0000, 8'(st_r.cur), 5'h00, st_r.req, st_r.state, st_r.en};
            else if (int'(st_r.ap_adr) >= int'(A_SLV) &&
                     int'(st_r.ap_adr) < int'(A_SLV) + (NSLV << SLV_SH))
            begin
                si = (int'(st_r.ap_adr) - int'(A_SLV)) >> SLV_SH;
                case (st_r.ap_adr[3:2])
                    R_CFG: rdw = st_r.cfg[si];
                    R_TIM: rdw = st_r.tim[si];
                    R_CTL: rdw = {16'h0000, st_r.ctl[si]};
                    default: rdw = {30'h0000_0000, st_r.sts[si]};
                endcase
                if (st_r.ap_wr)
                begin
                    case (st_r.ap_adr[3:2])
                        R_CFG: st_nxt.cfg[si] = hwdata;
                        R_TIM: st_nxt.tim[si] = hwdata;
                        R_CTL: st_nxt.ctl[si] = hwdata[15:0];
                        default: st_nxt.ctl[si] = st_r.ctl[si];
                    endcase
                end
            end
            else if (int'(st_r.ap_adr) >= int'(A_MSG) &&
                     int'(st_r.ap_adr) < int'(A_MSG) + (NM << MSG_SH))
            begin
                mi = (int'(st_r.ap_adr) - int'(A_MSG)) >> MSG_SH;
                rdw = st_r.ap_adr[2] ? {16'h0000, st_r.mctl[mi]} : st_r.madr[mi];
                if (st_r.ap_wr && st_r.ap_adr[2])
                    st_nxt.mctl[mi] = hwdata[15:0];
                else if (st_r.ap_wr)
                    st_nxt.madr[mi] = hwdata;
            end
            if (st_r.ap_wr && st_r.ap_adr == A_CTRL)
                st_nxt.en = hwdata[CTRL_EN];
            if (!st_r.ap_wr)
                st_nxt.hrdata = rdw;
        end
        else if (hsel && hready && htrans[1])
        begin
            st_nxt.ap_v = 1'b1;
            st_nxt.ap_wr = hwrite;
            st_nxt.ap_adr = {haddr[11:2], 2'b00};
            st_nxt.hrdy = 1'b0;
        end

        // Scheduler
        case (st_r.state)
            ST_PICK:
            begin
                for (int k = 0; k < NMSG; k++)
                begin
                    idx = MW'((int'(st_r.ptr[c]) + k) % NMSG);
                    mi = int'(c) * NMSG + int'(idx);
                    if (!found && st_r.madr[mi][MSG_USE] && st_r.mctl[mi] == 16'h0000)
                    begin
                        found = 1'b1;
                        fidx = idx;
                    end
                end
                mi = int'(c) * NMSG + int'(fidx);
                mw = st_r.madr[mi];
                fc = fc_sel(mw[15:0], mw[MSG_QTY +: 10], mw[MSG_WR]);
                if (!st_r.en || md == MD_INACT)
                    st_nxt.cur = nxt_slv(c);
                else if (st_r.gcnt[c] != 17'h00000)
                    st_nxt.cur = nxt_slv(c);
                else if (md == MD_ACT && found && !fc.legal)
                begin
                    st_nxt.sts[c] = STS_ERR;
                    st_nxt.ptr[c] = fidx + MW'(1);
                    st_nxt.cur = nxt_slv(c);
                end
                else if (md == MD_ACT && found)
                begin
                    st_nxt.req = 1'b1;
                    st_nxt.node = st_r.cfg[c][CFG_NODE +: 8];
                    st_nxt.func = fc.code;
                    st_nxt.addr = fc.off;
                    st_nxt.qty = mw[MSG_QTY +: 10];
                    st_nxt.wr = mw[MSG_WR];
                    st_nxt.ping = 1'b0;
                    st_nxt.discard = 1'b0;
                    st_nxt.cur_msg = fidx;
                    st_nxt.state = ST_WAIT;
                end
                else if (st_r.pcnt[c] == 17'h00000)
                begin
                    st_nxt.req = 1'b1;
                    st_nxt.node = st_r.cfg[c][CFG_NODE +: 8];
                    st_nxt.ping = 1'b1;
                    st_nxt.wr = 1'b0;
                    st_nxt.pcnt[c] = ld_ms(st_r.tim[c][TIM_PING +: 16]);
                    if (st_r.cfg[c][CFG_PMODE])
                    begin
                        st_nxt.func = FC_RD_HREG;
                        st_nxt.addr = st_r.cfg[c][CFG_PADR +: 16];
                        st_nxt.qty = Q_1;
                        st_nxt.discard = 1'b1;
                    end
                    else
                    begin
                        st_nxt.func = FC_ECHO;
                        st_nxt.addr = SUB_ECHO;
                        st_nxt.qty = 10'h000;
                        st_nxt.discard = 1'b0;
                    end
                    st_nxt.state = ST_WAIT;
                end
                else
                    st_nxt.cur = nxt_slv(c);
            end
            ST_WAIT:
            begin
                if (lnk_done)
                begin
                    st_nxt.req = 1'b0;
                    st_nxt.gcnt[c] = ld_ms(st_r.tim[c][TIM_GAP +: 16]);
                    st_nxt.cur = nxt_slv(c);
                    st_nxt.state = ST_PICK;
                    if (lnk_ok || lnk_illegal ||
                        ({1'b0, st_r.rtry[c]} + 5'h01 >= lim))
                    begin
                        st_nxt.rtry[c] = 4'h0;
                        if (!st_r.ping)
                            st_nxt.ptr[c] = st_r.cur_msg + MW'(1);
                        if (lnk_ok)
                            st_nxt.sts[c] = STS_OK;
                        else if (lnk_illegal)
                            st_nxt.sts[c] = STS_ERR;
                        else if (st_r.ping)
                            st_nxt.sts[c] = STS_UNAV;
                        else
                            st_nxt.sts[c] = STS_FAIL;
                    end
                    else
                        st_nxt.rtry[c] = st_r.rtry[c] + 4'h1;
                end
            end
            default: st_nxt.state = ST_PICK;
        endcase

        // Master and slave idle states override reported status
        for (int i = 0; i < NSLV; i++)
        begin
            if (!st_r.en)
                st_nxt.sts[i] = STS_UNAV;
            else if (mode_of(st_r.ctl[i]) == MD_INACT)
                st_nxt.sts[i] = STS_OK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
            st_r.cfg <= {NSLV{RST_CFG}};
            st_r.tim <= {NSLV{RST_TIM}};
            st_r.sts <= {NSLV{STS_UNAV}};
            st_r.hrdy <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign hreadyout = st_r.hrdy;
    assign hresp = 1'b0;
    assign hrdata = st_r.hrdata;
    assign lnk_req = st_r.req;
    assign lnk_node = st_r.node;
    assign lnk_func = st_r.func;
    assign lnk_addr = st_r.addr;
    assign lnk_qty = st_r.qty;
    assign lnk_write = st_r.wr;
    assign lnk_ping = st_r.ping;
    assign lnk_discard = st_r.discard;
    assign lnk_slave = st_r.cur;
    assign lnk_msg = st_r.cur_msg;

    // Helpers seen only by the checks below
    logic [3:0] h_rtry;
    logic [16:0] h_gcnt;
    logic [16:0] h_pcnt;
    mmpm_mode_t h_md;
    logic h_fail;
    assign h_rtry = st_r.rtry[st_r.cur];
    assign h_gcnt = st_r.gcnt[st_r.cur];
    assign h_pcnt = st_r.pcnt[st_r.cur];
    assign h_md = mode_of(st_r.ctl[st_r.cur]);
    assign h_fail = st_r.state == ST_WAIT && lnk_done && !lnk_ok && !lnk_illegal;

    AST_RETRY_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
        h_fail && ({1'b0, h_rtry} + 5'h01 < lim) |=>
        st_r.rtry[$past(st_r.cur)] == $past(h_rtry) + 4'h1) else $error("retry not counted");
    AST_GAP_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_r.req) |-> $past(h_gcnt) == 17'h00000) else $error("gap violated");
    AST_PING_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_r.req) && st_r.ping |-> $past(h_pcnt) == 17'h00000 &&
        (st_r.tim[st_r.cur][TIM_PING +: 16] == 16'h0000 || h_pcnt != 17'h00000))
        else $error("ping interval violated");
    AST_ECHO_PING: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.req && st_r.ping && !st_r.discard |-> st_r.func == FC_ECHO && st_r.addr == SUB_ECHO)
        else $error("bad echo ping");
    AST_REG_PING: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.req && st_r.ping && st_r.cfg[st_r.cur][CFG_PMODE] |->
        st_r.func == FC_RD_HREG && st_r.discard && st_r.qty == Q_1) else $error("bad reg ping");
    AST_POLL_ACTIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_r.req) && !st_r.ping |-> $past(h_md) == MD_ACT) else $error("poll not active");
    AST_INACT_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_r.req) |-> $past(h_md) != MD_INACT) else $error("inactive slave sent");
    AST_INACT_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.en && mode_of(st_r.ctl[0]) == MD_INACT |=> st_r.sts[0] == STS_OK)
        else $error("inactive status not 0");
    AST_MASTER_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !st_r.en |=> st_r.sts[0] == STS_UNAV) else $error("master off status not 1");
    AST_FAIL_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
        h_fail && !st_r.ping && st_r.en && h_md == MD_ACT && ({1'b0, h_rtry} + 5'h01 >= lim)
        |=> st_r.sts[$past(st_r.cur)] == STS_FAIL) else $error("failure not reported");
    AST_ILLEGAL: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.state == ST_WAIT && lnk_done && lnk_illegal && st_r.en && h_md != MD_INACT
        |=> st_r.sts[$past(st_r.cur)] == STS_ERR) else $error("illegal not reported");
    AST_LIST_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.state == ST_WAIT && lnk_done && lnk_ok && !st_r.ping
        |=> st_r.ptr[$past(st_r.cur)] == $past(st_r.cur_msg) + MW'(1)) else $error("order");
    AST_COILS_QTY: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.req && st_r.func == FC_WR_COILS |-> st_r.qty >= Q_2 && st_r.qty <= Q_BITS)
        else $error("multi coil count");
    AST_REGS_QTY: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r.req && st_r.func == FC_WR_REGS |-> st_r.qty >= Q_2 && st_r.qty <= Q_WREGS)
        else $error("multi reg count");
endmodule

// File: sim/mmpm_link_mdl.sv
// Link engine model: answers each request dly + 1 cycles after it rises.
// Assumes the poll manager's level request and one-cycle done pulse.
`timescale 1ns/1ps
module mmpm_link_mdl (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link handshake
    input wire logic lnk_req,
    output logic lnk_done,
    output logic lnk_ok,
    output logic lnk_illegal,
    // Answer kind: 0 valid, 1 silent, 2 exception
    input wire logic [1:0] rsp,
    input wire logic [3:0] dly
);
    logic [3:0] cnt;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 4'h0;
            lnk_done <= 1'b0;
        end
        else
        begin
            lnk_done <= lnk_req && !lnk_done && cnt == dly;
            cnt <= lnk_req ? cnt + 4'h1 : 4'h0;
        end
    end
    // An echo comes back unchanged, so it counts as a valid reply
    assign lnk_ok = lnk_done && rsp == 2'h0;
    assign lnk_illegal = lnk_done && rsp == 2'h2;
endmodule

// File: sim/tb.sv
// Bench: poll order, function codes, retries, status codes, gaps.
// Assumes the link model answers each request of the poll manager.
`timescale 1ns/1ps
module tb;
    import mmpm_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp;
    logic lnk_req, lnk_write, lnk_ping, lnk_done, lnk_ok, lnk_illegal, pr = 0;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0, rsp = 0, lnk_msg;
    logic lnk_discard, lnk_slave;
    logic [2:0] hsize = 3'h2;
    logic [3:0] dly = 4'h8;
    logic [31:0] hwdata = 0, hrdata, q, rs = 32'hBF1EF288;
    logic [7:0] lnk_node, lnk_func, tw = 8'hC6;
    logic [15:0] lnk_addr;
    logic [9:0] lnk_qty;
    logic [47:0] exq[$];
    logic [47:0] sn;
    logic [47:0] pe;
    logic [15:0] ta[8] = '{16'h0005, 16'h270F, 16'h0001, 16'h2711, 16'h7531, 16'hC34F,
        16'h9C41, 16'h9C41};
    logic [9:0] tq[8] = '{10'h001, 10'h001, 10'h200, 10'h001, 10'h07D, 10'h001, 10'h001, 10'h07B};
    logic [7:0] tf[8] = '{8'h01, 8'h05, 8'h15, 8'h02,
        8'h04, 8'h03, 8'h06, 8'h16};
    int fail_count = 0, tests_run = 0, cyc = 0, last = 0, gap = 0;
    assign hready = hreadyout;
    // Message index means nothing on a ping, so it is masked there
    assign sn = {lnk_slave, (lnk_ping ? 2'h0 : lnk_msg), lnk_discard, lnk_node, lnk_func,
        lnk_addr, lnk_qty, lnk_write, lnk_ping};
    mmpm_poll_mgr #(.NSLV(2), .NMSG(4), .MS_CYCLES(4)) mmpm_poll_mgr_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout, .hresp, .hrdata,
        .lnk_req, .lnk_node, .lnk_func, .lnk_addr, .lnk_qty, .lnk_write, .lnk_ping,
        .lnk_discard, .lnk_slave, .lnk_msg, .lnk_done, .lnk_ok, .lnk_illegal);
    mmpm_link_mdl mmpm_link_mdl_i (.hclk, .hresetn, .lnk_req, .lnk_done, .lnk_ok, .lnk_illegal,
        .rsp, .dly);
    initial
    begin
        forever #12.5 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(inout int n);
        @(posedge hclk);
        n++;
        if (n > 20000)
        begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do step(n); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do step(n); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(48'({hresp, q}), 48'(e));
    endtask
    // q_empty high: wait until the expected queue drains; else d high: wait for a reply, d low: wait until no request is open
    task automatic wt(input logic d, input logic q_empty);
        int n;
        n = 0;
        do step(n); while (q_empty ? exq.size() != 0 : d ? lnk_done !== 1'b1 : lnk_req !== 1'b0);
        step(n);
    endtask
    function automatic logic [47:0] ex(int j);
        logic [15:0] b;
        b = ta[j] < INP_LO ? COIL_LO : ta[j] < IREG_LO ? INP_LO :
            ta[j] < HREG_LO ? IREG_LO : HREG_LO;
        return {1'(j / 4), 2'(j % 4), 1'b0, 8'h11 * 8'(j / 4 + 1), tf[j], ta[j] - b, tq[j],
            tw[j], 1'b0};
    endfunction
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        pr <= lnk_req;
        if (lnk_req === 1'b1 && pr !== 1'b1)
        begin
            gap <= cyc - last;
            last <= cyc;
            if (exq.size() > 0)
                chk(sn, exq.pop_front());
        end
    end
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rs = xs(rs);
        tq[3] = 10'(rs % 512) + 10'h001;
        dly <= 4'h8 + 4'(rs[6:4]);
        rd(A_SLV + 12'h00C, 32'h1);
        rd(A_SLV, RST_CFG);
        rd(A_SLV + 12'h004, RST_TIM);
        rd(12'h100, 32'h0);
        for (int j = 0; j < 8; j++)
            ahb(1'b1, A_MSG + 12'(8 * j), {tw[j], 1'b1, 4'h0, tq[j], ta[j]});
        for (int s = 0; s < 2; s++)
        begin
            ahb(1'b1, A_SLV + 12'(16 * s), RST_CFG | 32'(8'h11 * 8'(s + 1)));
            ahb(1'b1, A_SLV + 12'(16 * s + 8), 32'(CTL_ACT));
        end
        for (int k = 0; k < 8; k++)
            exq.push_back(ex(k % 2 * 4 + k / 2));
        ahb(1'b1, A_CTRL, 32'h1);
        wt(1'b0, 1'b1);
        $display("poll order done");
        ahb(1'b1, A_CTRL, 32'h0);
        wt(1'b0, 1'b0);
        rd(A_SLV + 12'h01C, 32'h1);
        rsp <= 2'h1;
        ahb(1'b1, A_SLV + 12'h018, 32'h7);
        ahb(1'b1, A_MSG + 12'h004, 32'h1);
        ahb(1'b1, A_SLV + 12'h004, RST_TIM | 32'h5);
        exq = '{ex(1), ex(1), ex(1), ex(2)};
        ahb(1'b1, A_CTRL, 32'h1);
        wt(1'b0, 1'b1);
        chk(48'(gap >= 20), 48'h1);
        rd(A_SLV + 12'h00C, 32'(STS_FAIL));
        rd(A_SLV + 12'h01C, 32'(STS_OK));
        rsp <= 2'h2;
        wt(1'b1, 1'b0);
        rd(A_SLV + 12'h00C, 32'(STS_ERR));
        $display("retry and status done");
        ahb(1'b1, A_CTRL, 32'h0);
        wt(1'b0, 1'b0);
        rsp <= 2'h0;
        ahb(1'b1, A_SLV + 12'h008, 32'(CTL_STBY));
        pe = {4'h0, 8'h11, FC_ECHO, SUB_ECHO, 10'h000, 2'b01};
        exq = '{pe, pe};
        ahb(1'b1, A_CTRL, 32'h1);
        wt(1'b0, 1'b1);
        chk(48'(gap >= 4000), 48'h1);
        wt(1'b1, 1'b0);
        rd(A_SLV + 12'h00C, 32'(STS_OK));
        rsp <= 2'h1;
        // A failed ping is retried before the slave is reported unavailable
        repeat (int'(RST_CFG[CFG_RTRY +: 4]))
            wt(1'b1, 1'b0);
        rd(A_SLV + 12'h00C, 32'(STS_UNAV));
        rsp <= 2'h0;
        ahb(1'b1, A_SLV + 12'h004, 32'h0);
        ahb(1'b1, A_SLV, RST_CFG | 32'h1234_1011);
        pe = {4'h1, 8'h11, FC_RD_HREG, 16'h1234, Q_1, 2'b01};
        exq = '{pe};
        wt(1'b0, 1'b1);
        $display("ping done");
        final_report();
    end
endmodule
